// >>> rtl/tx_cfg_pkg.sv
package tx_cfg_pkg;

    // lane count of this build
    localparam int NUM_LANES = 4;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int NUM_EVT   = 2;

    // register byte offsets; the port carries word addresses
    localparam logic [9:0] OFS_ERR_STATUS  = 10'h060;
    localparam logic [9:0] OFS_ERR_ENABLE  = 10'h064;
    localparam logic [9:0] OFS_LANE_CTRL   = 10'h080;
    localparam logic [9:0] OFS_LINK_PARAM0 = 10'h090;
    localparam logic [9:0] OFS_LINK_PARAM1 = 10'h094;
    localparam logic [9:0] OFS_LINK_PARAM2 = 10'h098;
    localparam logic [9:0] OFS_TX_TEST     = 10'h0d0;
    localparam logic [9:0] OFS_PATTERN_A   = 10'h0d4;
    localparam logic [9:0] OFS_PATTERN_B   = 10'h0d8;
    localparam logic [9:0] OFS_PATTERN_C   = 10'h0dc;
    localparam logic [9:0] OFS_PATTERN_D   = 10'h0e0;

    // event bit positions in status and enable
    localparam int EVT_INVALID_DATA = 0;
    localparam int EVT_SYNC_REQ     = 1;

    // link_param0 fields
    localparam int P0_LANES_LSB  = 0;
    localparam int P0_OCTETS_LSB = 8;
    localparam int P0_FRAMES_LSB = 16;
    localparam int P0_CONV_LSB   = 24;
    // link_param1 fields
    localparam int P1_CTRLBITS_LSB = 0;
    localparam int P1_RES_LSB      = 8;
    localparam int P1_TOTBITS_LSB  = 16;
    localparam int P1_SAMPLES_LSB  = 24;
    // link_param2 fields
    localparam int P2_HD_LSB    = 0;
    localparam int P2_CWORD_LSB = 8;

    // reset values
    localparam logic [31:0] RST_LINK_PARAM0 = 32'h0000_0000;
    localparam logic [31:0] RST_LINK_PARAM1 = 32'h0000_0000;
    localparam logic [31:0] RST_LINK_PARAM2 = 32'h0000_0000;
    localparam logic [31:0] RST_PATTERN     = 32'h0000_0000;
    localparam logic [3:0]  RST_TEST_MODE   = 4'h0;
    localparam logic [NUM_EVT-1:0] RST_ERR_ENABLE = 2'h0;

endpackage

// >>> rtl/event_status_latch.sv
`timescale 1ns/10ps
module event_status_latch (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    // events and software control
    input  wire logic [tx_cfg_pkg::NUM_EVT-1:0] set_vec,
    input  wire logic [tx_cfg_pkg::NUM_EVT-1:0] clr_vec,
    input  wire logic [tx_cfg_pkg::NUM_EVT-1:0] enable_vec,
    // state
    output logic      [tx_cfg_pkg::NUM_EVT-1:0] status_q,
    output logic                             irq_q
);
    import tx_cfg_pkg::*;

    logic [NUM_EVT-1:0] status_d;
    logic               irq_d;

    always_comb begin
        // a set in the clearing cycle wins over the clear
        status_d = (status_q & ~clr_vec) | set_vec;
        irq_d    = |(status_d & enable_vec);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q    <= irq_d;
        end
    end
endmodule

// >>> rtl/loopback_tap.sv
`timescale 1ns/10ps
module loopback_tap (
    // clock and reset
    input  wire logic                             ref_clk,
    input  wire logic                             resetn,
    // data link layer side
    input  wire logic [tx_cfg_pkg::NUM_LANES*32-1:0] dll_lane_words,
    input  wire logic [tx_cfg_pkg::NUM_LANES*4-1:0]  dll_control_char_flags,
    input  wire logic [tx_cfg_pkg::NUM_LANES-1:0]    lane_powerdown,
    // loopback outputs
    output logic      [tx_cfg_pkg::NUM_LANES*32-1:0] loopback_lane_words,
    output logic      [tx_cfg_pkg::NUM_LANES*4-1:0]  loopback_control_char_flags
);
    import tx_cfg_pkg::*;

    logic [NUM_LANES*32-1:0] words_d;
    logic [NUM_LANES*4-1:0]  kflags_d;

    // powered-down lanes show zero so a receiver sees no stale data
    for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
        assign words_d[i*32 +: 32] = lane_powerdown[i] ? 32'h0000_0000 : dll_lane_words[i*32 +: 32];
        assign kflags_d[i*4 +: 4]  = lane_powerdown[i] ? 4'h0 : dll_control_char_flags[i*4 +: 4];
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            loopback_lane_words         <= '0;
            loopback_control_char_flags <= '0;
        end else begin
            loopback_lane_words         <= words_d;
            loopback_control_char_flags <= kflags_d;
        end
    end
endmodule

// >>> rtl/tx_link_config_sideband.sv
`timescale 1ns/10ps
module tx_link_config_sideband (
    // clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                resetn,
    // register slave port
    input  wire logic                                reg_port_cs,
    input  wire logic [tx_cfg_pkg::ADDR_W-1:0]       reg_port_word_addr,
    input  wire logic [tx_cfg_pkg::DATA_W-1:0]       reg_port_wdata,
    input  wire logic                                reg_port_rd,
    input  wire logic                                reg_port_wr,
    output logic      [tx_cfg_pkg::DATA_W-1:0]       reg_port_rdata,
    output logic                                     reg_port_stall,
    // event sources
    input  wire logic                                transport_invalid_data_flag,
    input  wire logic                                sync_request,
    // data link layer tap
    input  wire logic [tx_cfg_pkg::NUM_LANES*32-1:0] dll_lane_words,
    input  wire logic [tx_cfg_pkg::NUM_LANES*4-1:0]  dll_control_char_flags,
    // run-time link parameters
    output logic      [4:0]                          active_lane_count,
    output logic      [7:0]                          octets_per_frame,
    output logic      [4:0]                          frames_per_multiframe,
    output logic      [7:0]                          converter_count,
    output logic      [1:0]                          control_bits_per_sample,
    output logic      [4:0]                          converter_resolution,
    output logic      [4:0]                          total_bits_per_sample,
    output logic      [4:0]                          samples_per_converter,
    output logic                                     high_density_flag,
    output logic      [4:0]                          control_words_per_frame,
    output logic      [tx_cfg_pkg::NUM_LANES-1:0]    lane_powerdown,
    // interrupt
    output logic                                     tx_irq_out,
    // loopback and test
    output logic      [tx_cfg_pkg::NUM_LANES*32-1:0] loopback_lane_words,
    output logic      [tx_cfg_pkg::NUM_LANES*4-1:0]  loopback_control_char_flags,
    output logic      [3:0]                          test_mode,
    output logic      [31:0]                         test_pattern_a,
    output logic      [31:0]                         test_pattern_b,
    output logic      [31:0]                         test_pattern_c,
    output logic      [31:0]                         test_pattern_d
);
    import tx_cfg_pkg::*;

    // word addresses of each register
    localparam logic [ADDR_W-1:0] WA_ERR_STATUS  = OFS_ERR_STATUS[9:2];
    localparam logic [ADDR_W-1:0] WA_ERR_ENABLE  = OFS_ERR_ENABLE[9:2];
    localparam logic [ADDR_W-1:0] WA_LANE_CTRL   = OFS_LANE_CTRL[9:2];
    localparam logic [ADDR_W-1:0] WA_LINK_PARAM0 = OFS_LINK_PARAM0[9:2];
    localparam logic [ADDR_W-1:0] WA_LINK_PARAM1 = OFS_LINK_PARAM1[9:2];
    localparam logic [ADDR_W-1:0] WA_LINK_PARAM2 = OFS_LINK_PARAM2[9:2];
    localparam logic [ADDR_W-1:0] WA_TX_TEST     = OFS_TX_TEST[9:2];
    localparam logic [ADDR_W-1:0] WA_PATTERN_A   = OFS_PATTERN_A[9:2];
    localparam logic [ADDR_W-1:0] WA_PATTERN_B   = OFS_PATTERN_B[9:2];
    localparam logic [ADDR_W-1:0] WA_PATTERN_C   = OFS_PATTERN_C[9:2];
    localparam logic [ADDR_W-1:0] WA_PATTERN_D   = OFS_PATTERN_D[9:2];

    // control registers
    logic [31:0]          link_param0_q, link_param0_d;
    logic [31:0]          link_param1_q, link_param1_d;
    logic [31:0]          link_param2_q, link_param2_d;
    logic [NUM_LANES-1:0] lane_ctrl_q, lane_ctrl_d;
    logic [3:0]           tx_test_q, tx_test_d;
    logic [NUM_EVT-1:0]   err_enable_q, err_enable_d;
    logic [31:0]          pattern_q [4];
    logic [31:0]          pattern_d [4];

    logic                 wr_en;
    logic                 rd_en;
    logic [NUM_EVT-1:0]   evt_set;
    logic [NUM_EVT-1:0]   evt_clr;
    logic [NUM_EVT-1:0]   err_status;

    // word-addressed access; chip select gates both strobes
    assign wr_en = reg_port_cs & reg_port_wr;
    assign rd_en = reg_port_cs & reg_port_rd;

    // the port answers every access at once
    assign reg_port_stall = 1'b0;

    // register write decode
    always_comb begin
        link_param0_d = link_param0_q;
        link_param1_d = link_param1_q;
        link_param2_d = link_param2_q;
        lane_ctrl_d   = lane_ctrl_q;
        tx_test_d     = tx_test_q;
        err_enable_d  = err_enable_q;
        pattern_d     = pattern_q;
        if (wr_en) begin
            case (reg_port_word_addr)
                WA_LINK_PARAM0: link_param0_d = reg_port_wdata;
                WA_LINK_PARAM1: link_param1_d = reg_port_wdata;
                WA_LINK_PARAM2: link_param2_d = reg_port_wdata;
                WA_LANE_CTRL:   lane_ctrl_d   = reg_port_wdata[NUM_LANES-1:0];
                WA_TX_TEST:     tx_test_d     = reg_port_wdata[3:0];
                WA_ERR_ENABLE:  err_enable_d  = reg_port_wdata[NUM_EVT-1:0];
                WA_PATTERN_A:   pattern_d[0]  = reg_port_wdata;
                WA_PATTERN_B:   pattern_d[1]  = reg_port_wdata;
                WA_PATTERN_C:   pattern_d[2]  = reg_port_wdata;
                WA_PATTERN_D:   pattern_d[3]  = reg_port_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            link_param0_q <= RST_LINK_PARAM0;
            link_param1_q <= RST_LINK_PARAM1;
            link_param2_q <= RST_LINK_PARAM2;
            lane_ctrl_q   <= '0;
            tx_test_q     <= RST_TEST_MODE;
            err_enable_q  <= RST_ERR_ENABLE;
            for (int i = 0; i < 4; i++) begin
                pattern_q[i] <= RST_PATTERN;
            end
        end else begin
            link_param0_q <= link_param0_d;
            link_param1_q <= link_param1_d;
            link_param2_q <= link_param2_d;
            lane_ctrl_q   <= lane_ctrl_d;
            tx_test_q     <= tx_test_d;
            err_enable_q  <= err_enable_d;
            pattern_q     <= pattern_d;
        end
    end

    // exported values are the registers themselves
    always_comb begin
        active_lane_count       = link_param0_q[P0_LANES_LSB +: 5];
        octets_per_frame        = link_param0_q[P0_OCTETS_LSB +: 8];
        frames_per_multiframe   = link_param0_q[P0_FRAMES_LSB +: 5];
        converter_count         = link_param0_q[P0_CONV_LSB +: 8];
        control_bits_per_sample = link_param1_q[P1_CTRLBITS_LSB +: 2];
        converter_resolution    = link_param1_q[P1_RES_LSB +: 5];
        total_bits_per_sample   = link_param1_q[P1_TOTBITS_LSB +: 5];
        samples_per_converter   = link_param1_q[P1_SAMPLES_LSB +: 5];
        high_density_flag       = link_param2_q[P2_HD_LSB];
        control_words_per_frame = link_param2_q[P2_CWORD_LSB +: 5];
        lane_powerdown          = lane_ctrl_q;
        test_mode               = tx_test_q;
        test_pattern_a          = pattern_q[0];
        test_pattern_b          = pattern_q[1];
        test_pattern_c          = pattern_q[2];
        test_pattern_d          = pattern_q[3];
    end

    // events: invalid data from transport, sync request; write one to clear
    always_comb begin
        evt_set                   = '0;
        evt_set[EVT_INVALID_DATA] = transport_invalid_data_flag;
        evt_set[EVT_SYNC_REQ]     = sync_request;
        evt_clr                   = '0;
        if (wr_en && reg_port_word_addr == WA_ERR_STATUS) begin
            evt_clr = reg_port_wdata[NUM_EVT-1:0];
        end
    end

    event_status_latch u_status (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .set_vec    (evt_set),
        .clr_vec    (evt_clr),
        .enable_vec (err_enable_q),
        .status_q   (err_status),
        .irq_q      (tx_irq_out)
    );

    loopback_tap u_loopback (
        .ref_clk                     (ref_clk),
        .resetn                      (resetn),
        .dll_lane_words              (dll_lane_words),
        .dll_control_char_flags      (dll_control_char_flags),
        .lane_powerdown              (lane_ctrl_q),
        .loopback_lane_words         (loopback_lane_words),
        .loopback_control_char_flags (loopback_control_char_flags)
    );

    // read data returned in the access cycle; unmapped words read zero
    always_comb begin
        reg_port_rdata = '0;
        if (rd_en) begin
            case (reg_port_word_addr)
                WA_LINK_PARAM0: reg_port_rdata = link_param0_q;
                WA_LINK_PARAM1: reg_port_rdata = link_param1_q;
                WA_LINK_PARAM2: reg_port_rdata = link_param2_q;
                WA_LANE_CTRL:   reg_port_rdata[NUM_LANES-1:0] = lane_ctrl_q;
                WA_TX_TEST:     reg_port_rdata[3:0] = tx_test_q;
                WA_ERR_ENABLE:  reg_port_rdata[NUM_EVT-1:0] = err_enable_q;
                WA_ERR_STATUS:  reg_port_rdata[NUM_EVT-1:0] = err_status;
                WA_PATTERN_A:   reg_port_rdata = pattern_q[0];
                WA_PATTERN_B:   reg_port_rdata = pattern_q[1];
                WA_PATTERN_C:   reg_port_rdata = pattern_q[2];
                WA_PATTERN_D:   reg_port_rdata = pattern_q[3];
                default:        reg_port_rdata = '0;
            endcase
        end
    end

endmodule

// >>> sim/tx_sideband_chk.sv
`timescale 1ns/10ps
module tx_sideband_chk (
    // clock and reset
    input wire logic         ref_clk,
    input wire logic         resetn,
    // register port
    input wire logic         reg_port_cs,
    input wire logic [7:0]   reg_port_word_addr,
    input wire logic [31:0]  reg_port_wdata,
    input wire logic         reg_port_rd,
    input wire logic         reg_port_wr,
    input wire logic [31:0]  reg_port_rdata,
    input wire logic         reg_port_stall,
    // exported state
    input wire logic [127:0] dll_lane_words,
    input wire logic [4:0]   active_lane_count,
    input wire logic [7:0]   octets_per_frame,
    input wire logic [4:0]   frames_per_multiframe,
    input wire logic [7:0]   converter_count,
    input wire logic [3:0]   lane_powerdown,
    input wire logic         tx_irq_out,
    input wire logic [127:0] loopback_lane_words,
    input wire logic [3:0]   test_mode,
    input wire logic [31:0]  test_pattern_a
);
    import tx_cfg_pkg::*;
    logic         wr_en;
    logic [127:0] exp_words;
    always_comb begin
        wr_en = reg_port_cs && reg_port_wr;
        for (int i = 0; i < NUM_LANES; i++) begin
            exp_words[i*32+:32] = lane_powerdown[i] ? 32'h0 : dll_lane_words[i*32+:32];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    property p_no_stall; reg_port_stall == 1'b0; endproperty
    a_no_stall: assert property (p_no_stall) else $error("register port stalled");
    property p_pat_wr; wr_en && reg_port_word_addr == 8'h35 |=> test_pattern_a == $past(reg_port_wdata); endproperty
    a_pat_wr: assert property (p_pat_wr) else $error("pattern a missed a write");
    property p_pat_rd; reg_port_cs && reg_port_rd && reg_port_word_addr == 8'h35 |-> reg_port_rdata == test_pattern_a;
    endproperty
    a_pat_rd: assert property (p_pat_rd) else $error("pattern a read back wrong");
    property p_param0;
        wr_en && reg_port_word_addr == 8'h24 |=> {converter_count, 3'h0, frames_per_multiframe, octets_per_frame,
            3'h0, active_lane_count} == ($past(reg_port_wdata) & 32'hff1f_ff1f);
    endproperty
    a_param0: assert property (p_param0) else $error("link fields differ from write");
    property p_lane; wr_en && reg_port_word_addr == 8'h20 |=> {28'h0, lane_powerdown} == ($past(reg_port_wdata) & 32'hf);
    endproperty
    a_lane: assert property (p_lane) else $error("lane power-down differs from write");
    property p_test; wr_en && reg_port_word_addr == 8'h34 |=> {28'h0, test_mode} == ($past(reg_port_wdata) & 32'hf);
    endproperty
    a_test: assert property (p_test) else $error("test mode differs from write");
    property p_loop; $past(resetn) |-> loopback_lane_words == $past(exp_words); endproperty
    a_loop: assert property (p_loop) else $error("loopback words wrong");
    property p_irq_hold; (!wr_en)[*3] ##0 tx_irq_out |=> tx_irq_out; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without a write");
endmodule
bind tx_link_config_sideband tx_sideband_chk i_chk (
    .ref_clk(ref_clk), .resetn(resetn), .reg_port_cs(reg_port_cs), .reg_port_word_addr(reg_port_word_addr),
    .reg_port_wdata(reg_port_wdata), .reg_port_rd(reg_port_rd), .reg_port_wr(reg_port_wr),
    .reg_port_rdata(reg_port_rdata), .reg_port_stall(reg_port_stall), .dll_lane_words(dll_lane_words),
    .active_lane_count(active_lane_count), .octets_per_frame(octets_per_frame),
    .frames_per_multiframe(frames_per_multiframe), .converter_count(converter_count),
    .lane_powerdown(lane_powerdown), .tx_irq_out(tx_irq_out), .loopback_lane_words(loopback_lane_words),
    .test_mode(test_mode), .test_pattern_a(test_pattern_a)
);

// >>> sim/transport_model.sv
`timescale 1ns/10ps
module transport_model (
    // clock
    input  wire logic ref_clk,
    // scenario requests
    input  wire logic ev_invalid,
    input  wire logic ev_sync,
    // toward the transmit core
    output logic         transport_invalid_data_flag,
    output logic         sync_request,
    output logic [127:0] dll_lane_words,
    output logic [15:0]  dll_control_char_flags
);
    logic [31:0] beat = 32'h0;
    // data moves every cycle so a stale tap is seen
    // requests are taken on the edge, so the bench's settled levels are seen without a race
    always @(posedge ref_clk) begin
        beat                        <= beat + 32'h1;
        transport_invalid_data_flag <= ev_invalid;
        sync_request                <= ev_sync;
        dll_lane_words              <= {beat ^ 32'hc3c3_0000, beat ^ 32'h5a5a_0000, ~beat, beat};
        dll_control_char_flags      <= beat[15:0] ^ 16'ha5c3;
    end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/10ps
module testbench;
    import tx_cfg_pkg::*;
    logic         ref_clk, resetn, reg_port_cs, reg_port_rd, reg_port_wr, reg_port_stall, ev_invalid, ev_sync;
    logic         transport_invalid_data_flag, sync_request, high_density_flag, tx_irq_out;
    logic [1:0]   control_bits_per_sample;
    logic [3:0]   lane_powerdown, test_mode;
    logic [4:0]   active_lane_count, frames_per_multiframe, converter_resolution, total_bits_per_sample;
    logic [4:0]   samples_per_converter, control_words_per_frame;
    logic [7:0]   reg_port_word_addr, octets_per_frame, converter_count;
    logic [15:0]  dll_control_char_flags, loopback_control_char_flags;
    logic [31:0]  reg_port_wdata, reg_port_rdata, test_pattern_a, test_pattern_b, test_pattern_c, test_pattern_d;
    logic [127:0] dll_lane_words, loopback_lane_words;
    int           n_mismatch = 0;
    int           checks_done = 0;
    tx_link_config_sideband i_dut (
        .ref_clk(ref_clk), .resetn(resetn), .reg_port_cs(reg_port_cs), .reg_port_word_addr(reg_port_word_addr),
        .reg_port_wdata(reg_port_wdata), .reg_port_rd(reg_port_rd), .reg_port_wr(reg_port_wr),
        .reg_port_rdata(reg_port_rdata), .reg_port_stall(reg_port_stall), .sync_request(sync_request),
        .transport_invalid_data_flag(transport_invalid_data_flag), .dll_lane_words(dll_lane_words),
        .dll_control_char_flags(dll_control_char_flags), .active_lane_count(active_lane_count),
        .octets_per_frame(octets_per_frame), .frames_per_multiframe(frames_per_multiframe),
        .converter_count(converter_count), .control_bits_per_sample(control_bits_per_sample),
        .converter_resolution(converter_resolution), .total_bits_per_sample(total_bits_per_sample),
        .samples_per_converter(samples_per_converter), .high_density_flag(high_density_flag),
        .control_words_per_frame(control_words_per_frame), .lane_powerdown(lane_powerdown), .tx_irq_out(tx_irq_out),
        .loopback_lane_words(loopback_lane_words), .loopback_control_char_flags(loopback_control_char_flags),
        .test_mode(test_mode), .test_pattern_a(test_pattern_a), .test_pattern_b(test_pattern_b),
        .test_pattern_c(test_pattern_c), .test_pattern_d(test_pattern_d));
    transport_model i_far (.ref_clk(ref_clk), .ev_invalid(ev_invalid), .ev_sync(ev_sync),
        .transport_invalid_data_flag(transport_invalid_data_flag), .sync_request(sync_request),
        .dll_lane_words(dll_lane_words), .dll_control_char_flags(dll_control_char_flags));
    task automatic check(input logic [127:0] seen, input logic [127:0] want);
        checks_done++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        step(1);
        {reg_port_cs, reg_port_wr, reg_port_word_addr, reg_port_wdata} = {2'b11, a, d};
        step(1);
        {reg_port_cs, reg_port_wr} = 2'b00;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        step(1);
        {reg_port_cs, reg_port_rd, reg_port_word_addr} = {2'b11, a};
        #5;
        d = reg_port_rdata;
        step(1);
        {reg_port_cs, reg_port_rd} = 2'b00;
    endtask
    task automatic inject(input logic inv, input logic syn);
        {ev_invalid, ev_sync} = {inv, syn};
        step(1);
        {ev_invalid, ev_sync} = 2'b00;
        step(4);
    endtask
    function automatic logic [31:0] pat(input int i);
        return 32'h0f1e_2d3c ^ {i[7:0], 24'h5a_a5c3};
    endfunction
    task automatic t_patterns();
        logic [31:0] d;
        check({test_pattern_a, test_pattern_b, test_pattern_c, test_pattern_d}, {4{RST_PATTERN}});
        for (int i = 0; i < 4; i++) reg_write(8'h35 + i[7:0], pat(i));
        reg_write(8'h39, 32'hffff_ffff);
        check({test_pattern_a, test_pattern_b, test_pattern_c, test_pattern_d},
              {pat(0), pat(1), pat(2), pat(3)});
        for (int i = 0; i < 4; i++) begin
            reg_read(8'h35 + i[7:0], d);
            check(d, pat(i));
        end
        reg_read(8'h39, d);
        check({reg_port_stall, d}, 33'h0);
        $display("test patterns done");
    endtask
    task automatic t_params();
        logic [31:0] w0, w1, w2;
        {w0, w1, w2} = {32'hc3f7_a5fd, 32'hbe9a_f6f7, 32'hffff_f3ff};
        check({active_lane_count, converter_count, lane_powerdown, test_mode, tx_irq_out}, 22'h0);
        reg_write(8'h24, w0);
        reg_write(8'h25, w1);
        reg_write(8'h26, w2);
        reg_write(8'h20, 32'hffff_fff5);
        reg_write(8'h34, 32'h0000_00fa);
        check(active_lane_count, w0[P0_LANES_LSB+:5]);
        check(octets_per_frame, w0[P0_OCTETS_LSB+:8]);
        check(frames_per_multiframe, w0[P0_FRAMES_LSB+:5]);
        check(converter_count, w0[P0_CONV_LSB+:8]);
        check(control_bits_per_sample, w1[P1_CTRLBITS_LSB+:2]);
        check(converter_resolution, w1[P1_RES_LSB+:5]);
        check(total_bits_per_sample, w1[P1_TOTBITS_LSB+:5]);
        check(samples_per_converter, w1[P1_SAMPLES_LSB+:5]);
        check(high_density_flag, w2[P2_HD_LSB]);
        check(control_words_per_frame, w2[P2_CWORD_LSB+:5]);
        check({lane_powerdown, test_mode}, 8'h5a);
        $display("test params done");
    endtask
    task automatic t_irq();
        logic [31:0] d;
        reg_write(8'h19, 32'h1);
        inject(1'b0, 1'b1);
        reg_read(8'h18, d);
        check({tx_irq_out, d}, 33'h2);
        inject(1'b1, 1'b0);
        check(tx_irq_out, 1'b1);
        step(6);
        check(tx_irq_out, 1'b1);
        reg_write(8'h18, 32'h1);
        step(2);
        check(tx_irq_out, 1'b0);
        reg_write(8'h19, 32'h3);
        step(2);
        check(tx_irq_out, 1'b1);
        reg_write(8'h18, 32'h2);
        step(2);
        check(tx_irq_out, 1'b0);
        $display("test interrupt done");
    endtask
    task automatic t_loop();
        logic [127:0] w;
        logic [15:0]  f;
        logic [3:0]   pd;
        for (int p = 0; p < 2; p++) begin
            pd = p ? 4'ha : 4'h5;
            reg_write(8'h20, {28'h0, pd});
            #1;
            {w, f} = {dll_lane_words, dll_control_char_flags};
            for (int i = 0; i < 4; i++) if (pd[i]) {w[i*32+:32], f[i*4+:4]} = 36'h0;
            step(1);
            check(loopback_lane_words, w);
            check(loopback_control_char_flags, f);
        end
        $display("test loopback done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #20000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        {resetn, reg_port_cs, reg_port_rd, reg_port_wr, ev_invalid, ev_sync} = 6'h0;
        {reg_port_word_addr, reg_port_wdata} = 40'h0;
        step(5);
        resetn = 1'b1;
        t_patterns();
        t_params();
        t_irq();
        t_loop();
        give_verdict();
    end
endmodule
